// ### rtl/olfm_pkg.sv
package olfm_pkg;

	// ====================================================================
	// register access codes (address byte bits between operation bit
	// and the last address bit flag)
	localparam logic [4:0] OLFM_ADDR_OL_5_8  = 5'h11; // 100 01
	localparam logic [4:0] OLFM_ADDR_OL_9_12 = 5'h09; // 010 01
	localparam logic [7:0] OLFM_OL_RESET     = 8'h00;
	localparam logic [7:0] OLFM_RSVD_MASK    = 8'h0F;
	localparam int         OLFM_BRIDGE_CNT   = 6;

	// ====================================================================
	// oscillator modulation timing
	localparam int         OLFM_CLK_MHZ      = 125;
	localparam int         OLFM_BASE_MHZ     = 8;
	localparam int         OLFM_FM_BASE_HZ   = 15625; // slowest mod rate
	localparam int         OLFM_FM_DIV_BASE  =
		(OLFM_CLK_MHZ * 1000000) / (2 * OLFM_FM_BASE_HZ);
	localparam logic [13:0] OLFM_FM_DIV_MAX  =
		14'(OLFM_FM_DIV_BASE - 1);
	localparam int         OLFM_BASE_DIV     = OLFM_CLK_MHZ / OLFM_BASE_MHZ;
	localparam logic [4:0] OLFM_BASE_NOM     = 5'(OLFM_BASE_DIV);
	localparam logic [1:0] OLFM_FM_OFF       = 2'h0;

	// per-bridge flag pair
	typedef struct packed {
		logic high;
		logic low;
	} olfm_pair_t;

	// read request from the command interface
	typedef struct packed {
		logic       valid;
		logic       last_address_bit_flag;
		logic [4:0] addr;
	} olfm_rd_t;

endpackage : olfm_pkg

// ### rtl/olfm_osc.sv
`timescale 1ns/1ps
module olfm_osc (
	input  wire logic                mclk,
	input  wire logic                reset,
	input  wire logic [1:0]          oscillator_modulation_select,
	output logic                     base_tick,
	output logic                     fm_phase
);
	import olfm_pkg::*;

	logic [13:0] fm_cnt_reg;
	logic [4:0]  base_cnt_reg;
	logic [13:0] fm_limit;
	logic [4:0]  base_period;

	// half-period of modulation: 01 slowest, each step halves it
	always_comb begin
		case (oscillator_modulation_select)
			2'h1:    fm_limit = OLFM_FM_DIV_MAX;
			2'h2:    fm_limit = 14'(OLFM_FM_DIV_MAX >> 1);
			default: fm_limit = 14'(OLFM_FM_DIV_MAX >> 2);
		endcase
	end

	// modulation phase toggles at the selected rate
	always_ff @(posedge mclk) begin
		if (reset || oscillator_modulation_select == OLFM_FM_OFF) begin
			fm_cnt_reg <= 14'h0000;
			fm_phase   <= 1'b0;
		end else if (fm_cnt_reg >= fm_limit) begin
			fm_cnt_reg <= 14'h0000;
			fm_phase   <= ~fm_phase;
		end else begin
			fm_cnt_reg <= fm_cnt_reg + 14'h0001;
		end
	end

	// base clock period stretched by one in the upper phase
	assign base_period = fm_phase ? OLFM_BASE_NOM + 5'h01 : OLFM_BASE_NOM;

	// base oscillator enable pulse
	always_ff @(posedge mclk) begin
		if (reset) begin
			base_cnt_reg <= 5'h00;
			base_tick    <= 1'b0;
		end else if (base_cnt_reg >= base_period - 5'h01) begin
			base_cnt_reg <= 5'h00;
			base_tick    <= 1'b1;
		end else begin
			base_cnt_reg <= base_cnt_reg + 5'h01;
			base_tick    <= 1'b0;
		end
	end

	chk_fm_off_still : assert property (@(posedge mclk) disable iff (reset)
		oscillator_modulation_select == OLFM_FM_OFF |=> !fm_phase)
		else $error("modulation phase moved while off");

endmodule : olfm_osc

// ### rtl/olfm_status.sv
`timescale 1ns/1ps
module olfm_status (
	input  wire logic                mclk,
	input  wire logic                reset,
	input  wire olfm_pkg::olfm_pair_t [5:0] open_load_detect,
	input  wire olfm_pkg::olfm_rd_t  rd_req,
	input  wire logic [1:0]          oscillator_modulation_select,
	output logic [7:0]               rd_data,
	output logic                     rd_valid,
	output logic                     base_tick,
	output logic                     fm_phase
);
	import olfm_pkg::*;

	olfm_pair_t [5:0] flag_reg;
	olfm_pair_t [5:0] flag_next;
	logic             hit_lo;
	logic             hit_hi;
	logic [7:0]       word_lo;
	logic [7:0]       word_hi;

	// ====================================================================
	// address decode
	// a strobe without the last address bit flag, or with any other code,
	// is ignored: no answer pulse, no clear, read data left as it was
	always_comb begin
		hit_lo = 1'b0;
		hit_hi = 1'b0;
		if (rd_req.valid && rd_req.last_address_bit_flag &&
			rd_req.addr == OLFM_ADDR_OL_5_8) begin
			hit_lo = 1'b1;
		end else if (rd_req.valid && rd_req.last_address_bit_flag &&
			rd_req.addr == OLFM_ADDR_OL_9_12) begin
			hit_hi = 1'b1;
		end
	end

	// bridge 8 high at bit 7 down to bridge 5 low at bit 0
	assign word_lo = {flag_reg[3], flag_reg[2], flag_reg[1], flag_reg[0]};
	assign word_hi = {4'h0, flag_reg[5], flag_reg[4]} & OLFM_RSVD_MASK;

	// ====================================================================
	// per-bridge sticky flags, detection wins over read clear
	for (genvar i = 0; i < OLFM_BRIDGE_CNT; i++) begin : g_flag
		logic clr;
		assign clr = (i < 4) ? hit_lo : hit_hi;
		always_comb begin
			flag_next[i] = clr ? 2'b00 : flag_reg[i];
			flag_next[i] = flag_next[i] | open_load_detect[i];
		end
		always_ff @(posedge mclk) begin
			if (reset) begin
				flag_reg[i] <= 2'b00;
			end else begin
				flag_reg[i] <= flag_next[i];
			end
		end
	end

	// read data captured before clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			rd_data  <= OLFM_OL_RESET;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= hit_lo | hit_hi;
			if (hit_lo) begin
				rd_data <= word_lo;
			end else if (hit_hi) begin
				rd_data <= word_hi;
			end
		end
	end

	// ====================================================================
	// frequency modulated base oscillator
	olfm_osc u_osc (
		.mclk                         (mclk),
		.reset                        (reset),
		.oscillator_modulation_select (oscillator_modulation_select),
		.base_tick                    (base_tick),
		.fm_phase                     (fm_phase)
	);

	chk_latch_set : assert property (@(posedge mclk) disable iff (reset)
		open_load_detect[0].low |=> flag_reg[0].low)
		else $error("detection not latched");
	chk_latch_hold : assert property (@(posedge mclk) disable iff (reset)
		flag_reg[2].high && !hit_lo |=> flag_reg[2].high)
		else $error("flag dropped without read");
	chk_read_lo : assert property (@(posedge mclk) disable iff (reset)
		hit_lo |=> rd_valid && rd_data == $past(word_lo))
		else $error("bridge 5-8 read wrong");
	chk_read_hi : assert property (@(posedge mclk) disable iff (reset)
		hit_hi |=> rd_valid && rd_data[3:0] == $past(word_hi[3:0]))
		else $error("bridge 9-10 read wrong");
	chk_rsvd_zero : assert property (@(posedge mclk) disable iff (reset)
		rd_valid && $past(hit_hi) |-> rd_data[7:4] == 4'h0)
		else $error("reserved bits not zero");
	chk_read_clear : assert property (@(posedge mclk) disable iff (reset)
		hit_lo && !open_load_detect[1].high |=> !flag_reg[1].high)
		else $error("flag not cleared by read");
	chk_reset_zero : assert property (@(posedge mclk)
		reset |=> flag_reg == '0)
		else $error("flags not zero after reset");
	// base tick comes back after 15 clocks, 16 in the upper phase
	chk_tick_period : assert property (@(posedge mclk) disable iff (reset)
		base_tick |-> ##[15:16] base_tick)
		else $error("base tick missing");

	// ====================================================================
	// further checks on the read interface, the flags and the base oscillator
	// these guard the corners that random reads seldom reach: refused
	// strobes, a set and a clear in one cycle, reads of one register
	// leaving the other register alone

	// strobe without last address bit flag gives no answer
	chk_refuse_flag : assert property (@(posedge mclk) disable iff (reset)
		rd_req.valid && !rd_req.last_address_bit_flag |=> !rd_valid)
		else $error("read without flag answered");

	// unknown register code gives no answer
	chk_refuse_addr : assert property (@(posedge mclk) disable iff (reset)
		rd_req.valid && rd_req.addr != OLFM_ADDR_OL_5_8 &&
		rd_req.addr != OLFM_ADDR_OL_9_12 |=> !rd_valid)
		else $error("unknown code answered");

	// answer pulse only after an accepted read
	chk_valid_pulse : assert property (@(posedge mclk) disable iff (reset)
		!hit_lo && !hit_hi |=> !rd_valid)
		else $error("answer pulse without read");

	// read data holds between accepted reads
	chk_hold_data : assert property (@(posedge mclk) disable iff (reset)
		!hit_lo && !hit_hi |=> $stable(rd_data))
		else $error("read data moved without read");

	// detection in the read cycle survives the clear
	chk_set_wins : assert property (@(posedge mclk) disable iff (reset)
		hit_lo && open_load_detect[3].high |=> flag_reg[3].high)
		else $error("detection lost to read clear");

	// read of bridges 9-10 clears their flags
	chk_clear_hi : assert property (@(posedge mclk) disable iff (reset)
		hit_hi && !open_load_detect[5].low |=> !flag_reg[5].low)
		else $error("bridge 10 flag not cleared");

	// bridge 9 flag held until its own register is read
	chk_hi_hold : assert property (@(posedge mclk) disable iff (reset)
		flag_reg[4].high && !hit_hi |=> flag_reg[4].high)
		else $error("bridge 9 flag dropped");

	// reading bridges 9-10 leaves bridges 5-8 alone
	chk_no_cross : assert property (@(posedge mclk) disable iff (reset)
		hit_hi && flag_reg[0].low |=> flag_reg[0].low)
		else $error("wrong register cleared");

	// outputs quiet after reset
	chk_reset_out : assert property (@(posedge mclk)
		reset |=> !rd_valid && rd_data == OLFM_OL_RESET)
		else $error("read outputs not quiet after reset");

	// base tick is a single pulse with a long gap behind it
	chk_tick_gap : assert property (@(posedge mclk) disable iff (reset)
		base_tick |=> !base_tick [*8])
		else $error("base ticks too close");

	// modulation phase moves while modulation is off only in its first clock, when a high phase clears to low
	chk_fm_hold : assert property (@(posedge mclk) disable iff (reset)
		oscillator_modulation_select == OLFM_FM_OFF
		|=> $stable(fm_phase))
		else $error("phase moved while off");

	// both flags of a bridge latch together on a double detection
	chk_pair_set : assert property (@(posedge mclk) disable iff (reset)
		open_load_detect[2] == 2'b11 |=> flag_reg[2] == 2'b11)
		else $error("flag pair not latched");

	// a read of bridges 5-8 clears bridge 8 when nothing is detected
	chk_clear_b8 : assert property (@(posedge mclk) disable iff (reset)
		hit_lo && open_load_detect[3] == 2'b00
		|=> flag_reg[3] == 2'b00)
		else $error("bridge 8 flags not cleared");

	// read of bridges 9-10 reports the latched pair of bridge 10
	chk_read_b10 : assert property (@(posedge mclk) disable iff (reset)
		hit_hi |=> rd_data[3:2] == $past(flag_reg[5]))
		else $error("bridge 10 bits misplaced");

endmodule : olfm_status

// ### verification/olfm_host.sv
`timescale 1ns/1ps
module olfm_host (
	input  wire logic          mclk,
	output olfm_pkg::olfm_rd_t rd_req,
	input  wire logic [7:0]    rd_data,
	input  wire logic          rd_valid
);
	import olfm_pkg::*;
	initial rd_req = '0;
	// ==================================================================
	// one read strobe, answer taken one cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic f,
		output logic [7:0] d, output logic v);
		@(negedge mclk);
		rd_req = '{1'b1, f, a};
		@(negedge mclk);
		rd_req = '{1'b0, ~f, ~a}; // released fields no longer hold
		v = rd_valid;
		d = rd_data;
	endtask : rd
endmodule : olfm_host

// ### verification/olfm_status_tb.sv
`timescale 1ns/1ps
module olfm_status_tb;
	import olfm_pkg::*;
	logic                   mclk = 0;
	logic                   reset = 1;
	logic [1:0]             sel = 2'h0;
	olfm_pair_t [5:0]       det = '0;
	olfm_rd_t               rq;
	logic [7:0]             rdd, d;
	logic                   rv, bt, fp, v;
	logic [16:0]            lfsr = 17'h121B7;
	logic [11:0]            p;
	int                     miscompares = 0, samples_checked = 0, n;
	always #4 mclk = ~mclk;
	olfm_status dut (.mclk(mclk), .reset(reset), .open_load_detect(det),
		.rd_req(rq), .oscillator_modulation_select(sel), .rd_data(rdd),
		.rd_valid(rv), .base_tick(bt), .fm_phase(fp));
	olfm_host host (.mclk(mclk), .rd_req(rq), .rd_data(rdd),
		.rd_valid(rv));
	// ==================================================================
	// helpers
	function automatic logic [16:0] nx(logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : nx
	task automatic chk(logic [15:0] s, logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic gap(output int c);
		logic x;
		x = fp;
		c = 0;
		while (fp === x && c < 9000) begin
			@(negedge mclk);
			c++;
		end
	endtask : gap
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	// watchdog against a hang
	initial begin
		repeat (70000) @(posedge mclk);
		miscompares++;
		final_report();
	end
	// ==================================================================
	// main sequence
	initial begin
		repeat (20) @(posedge mclk);
		@(negedge mclk) reset = 0;
		host.rd(5'h11, 1'b1, d, v); chk(d, 8'h00);
		host.rd(5'h09, 1'b1, d, v); chk(d, 8'h00);
		for (int i = 0; i < 8; i++) begin
			lfsr = nx(lfsr);
			p = lfsr[11:0] | (i == 0 ? 12'hFFF : 12'h000);
			@(negedge mclk) det = p;
			@(negedge mclk) det = '0;
			host.rd(5'h11, 1'b0, d, v); chk(v, 1'b0);
			host.rd(5'h0B, 1'b1, d, v); chk(v, 1'b0);
			host.rd(5'h11, 1'b1, d, v); chk(d, p[7:0]);
			chk(v, 1'b1);
			host.rd(5'h09, 1'b1, d, v); chk(d, {4'h0, p[11:8]});
			host.rd(5'h11, 1'b1, d, v); chk(d, 8'h00);
			host.rd(5'h09, 1'b1, d, v); chk(d, 8'h00);
		end
		n = 0;
		repeat (5000) @(negedge mclk) n += (fp !== 1'b0);
		chk(16'(n), 16'h0000);
		// unmodulated base tick spacing
		while (bt !== 1'b1) @(negedge mclk);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (bt !== 1'b1 && n < 100);
		chk(16'(n), 16'(OLFM_CLK_MHZ / OLFM_BASE_MHZ));
		for (int s = 1; s < 4; s++) begin
			@(negedge mclk) sel = 2'(s);
			gap(n);
			gap(n);
			chk(16'(n), 16'((2 * OLFM_FM_DIV_BASE) >> s));
		end
		final_report();
	end
endmodule : olfm_status_tb
